//--- flag_bank_map.vh
// Register map, field positions, reset values and timing for the flag bank.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef FLAG_BANK_MAP_VH
`define FLAG_BANK_MAP_VH

// ****************************************
// Bus and register offsets
// ****************************************
`define ADDR_W 8
`define OFF_STATUS 8'h00
`define OFF_CTRL 8'h04
`define OFF_LEDSEL 8'h08
`define OFF_LEDST 8'h0c
`define OFF_WDOG 8'h10
`define OFF_LINK 8'h14
`define OFF_HEADIO 8'h18
`define OFF_CLK0 8'h20
`define CLK_IDX_MASK 8'h0c
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// ****************************************
// Control register fields
// ****************************************
`define CTL_W 6
`define CTL_ERST 0
`define CTL_LEDOFF 1
`define CTL_PEN 2
`define CTL_CSET 3
`define CTL_CRD 4
`define CTL_CHG 5
`define CTL_RST 6'h00

// ****************************************
// Sticky flag positions (status bits 9:0)
// ****************************************
`define NSTICKY 10
`define F_SUM 0
`define F_SELF 1
`define F_COM 2
`define F_IND 3
`define F_BATL 4
`define F_DIP 5
`define F_OPE 6
`define F_FUSE 7
`define F_VER 8
`define F_CHK 9
// Error reset clears all but the supply-dip flag
`define CLR_ON_ERST 10'h3df

// ****************************************
// Reset values and clock data limits (BCD)
// ****************************************
`define WORD_RST 16'h0000
`define BCD_MON_MIN 8'h01
`define BCD_MON_MAX 8'h12
`define BCD_DAY_MIN 8'h01
`define BCD_DAY_MAX 8'h31
`define BCD_HOUR_MAX 8'h23
`define BCD_MS_MAX 8'h59
`define BCD_DOW_MAX 8'h06
`define BCD_YEAR_MAX 8'h99
`define BCD_ZERO 8'h00
`define BCD_DIGIT_MAX 4'h9

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 10
`define NS_PER_MS 1000000
`define DIP_AC_MS 20
`define DIP_DC_MS 1

`endif

//--- sync2.v
// Two-stage synchroniser for a group of asynchronous level inputs.
// Assumes the inputs are quasi-static levels; no bus coherency is implied.
`timescale 1ns/1ns
module sync2 #(
  parameter W = 1
)(
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= {W{1'b0}};
      q <= {W{1'b0}};
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

//--- sticky_bits.v
// Vector of sticky flags: a set holds until a clear, set winning a tie.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ns
module sticky_bits #(
  parameter W = 1
)(
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [W-1:0] set,
  input wire [W-1:0] clr,
  output reg [W-1:0] q
);
  always @(posedge aclk) begin
    if (!aresetn) begin
      q <= {W{1'b0}};
    end else if (ce) begin
      q <= set | (q & ~clr);
    end
  end
endmodule

//--- plc_system_flag_bank.v
// System flag bank of a controller CPU with an AXI4-Lite register port.
// Assumes scan strobes, error events and the clock value come from logic
// on aclk; fuse, battery, supply, switch and verify inputs are pins.
//
// Overview of operation
// - Summary flag sets on any error, sticky
// - Self-diag flag excludes annunciator and check, sticky
// - Info flags set only while summary flag set
// - Latched battery flag drives alarm indicator
// - Live battery flag follows battery level
// - AC outage up to 20ms sets dip
// - DC outage up to 1ms sets dip
// - Operation error flag sets and holds
// - Blown fuse flag sets and holds
// - Module mismatch flag sets and holds
// - Annunciator flag updates on instruction execution
// - Check instruction error flag sets and holds
// - Watchdog bits run timers, only with chart
// - LED-off edge darkens selected LEDs
// - Contacts show stopped, paused, single-step states
// - Pause entered only when pause enabled
// - Clock set writes at next scan end
// - Clock error flag reflects data validity
// - Clock read copies clock into words
// - One module replacement per change setting
// - Link inhibit bits skip refresh transfers
`timescale 1ns/1ns
`include "flag_bank_map.vh"
module plc_system_flag_bank #(
  parameter LEDS = 16,
  parameter WDOGS = 10,
  parameter LINKS = 4,
  parameter DIP_W = 22,
  parameter DIP_AC_CYC = `DIP_AC_MS * (`NS_PER_MS / `CLK_PERIOD_NS),
  parameter DIP_DC_CYC = `DIP_DC_MS * (`NS_PER_MS / `CLK_PERIOD_NS)
)(
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [`ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire fuse_blown,
  input wire battery_low,
  input wire power_ok,
  input wire supply_is_dc,
  input wire stop_switch,
  input wire pause_switch,
  input wire step_switch,
  input wire module_mismatch,
  input wire self_diag_err,
  input wire check_err,
  input wire op_err,
  input wire annunciator_any,
  input wire instr_exec,
  input wire common_info_avail,
  input wire indiv_info_avail,
  input wire end_of_scan,
  input wire [63:0] rtc_now,
  input wire sfc_present,
  input wire [LINKS-1:0] link_rd_req,
  input wire [LINKS-1:0] link_wr_req,
  input wire module_change_done,
  output reg [LEDS-1:0] led_enable,
  output wire battery_alarm_indicator,
  output wire stopped_contact,
  output wire paused_contact,
  output wire single_step_contact,
  output reg rtc_wr,
  output reg [63:0] rtc_wr_data,
  output reg [WDOGS-1:0] step_timer_run,
  output reg [LINKS-1:0] link_rd_go,
  output reg [LINKS-1:0] link_wr_go,
  output reg module_change_grant,
  output reg [15:0] change_io
);
  localparam AW = `ADDR_W;
  localparam [DIP_W-1:0] AC_LIM = DIP_AC_CYC;
  localparam [DIP_W-1:0] DC_LIM = DIP_DC_CYC;
  localparam [DIP_W-1:0] DIP_MAX = {DIP_W{1'b1}};
  localparam [3:0] S_RUN = 4'b0001;
  localparam [3:0] S_STOP = 4'b0010;
  localparam [3:0] S_PAUSE = 4'b0100;
  localparam [3:0] S_STEP = 4'b1000;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire [7:0] pin_s;
  sync2 #(.W(8)) u_pins (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .d({module_mismatch, step_switch, pause_switch, stop_switch,
        supply_is_dc, power_ok, battery_low, fuse_blown}),
    .q(pin_s)
  );
  wire fuse_s = pin_s[0];
  wire bat_s = pin_s[1];
  wire pok_s = pin_s[2];
  wire dc_s = pin_s[3];
  wire stop_s = pin_s[4];
  wire pause_s = pin_s[5];
  wire step_s = pin_s[6];
  wire mism_s = pin_s[7];

  // ****************************************
  // Software registers
  // ****************************************
  reg [`CTL_W-1:0] ctrl_r;
  reg [`CTL_W-1:0] ctrl_d_r;
  reg [LEDS-1:0] ledsel_r;
  reg [WDOGS-1:0] wdog_r;
  reg [2*LINKS-1:0] link_r;
  reg [15:0] headio_r;
  reg [15:0] clkw_r [0:3];
  wire [`CTL_W-1:0] ctl_rise = ctrl_r & ~ctrl_d_r;
  wire erst = ctl_rise[`CTL_ERST];

  // ****************************************
  // Sticky diagnostic flags
  // ****************************************
  wire [`NSTICKY-1:0] sticky;
  reg [`NSTICKY-1:0] st_set;
  reg dip_evt;
  wire any_self = self_diag_err | op_err | fuse_s | mism_s | bat_s;

  always @* begin
    st_set = {`NSTICKY{1'b0}};
    st_set[`F_SUM] = any_self | annunciator_any | check_err;
    st_set[`F_SELF] = any_self;
    st_set[`F_COM] = (sticky[`F_SUM] | st_set[`F_SUM]) & common_info_avail;
    st_set[`F_IND] = (sticky[`F_SUM] | st_set[`F_SUM]) & indiv_info_avail;
    st_set[`F_BATL] = bat_s;
    st_set[`F_DIP] = dip_evt;
    st_set[`F_OPE] = op_err;
    st_set[`F_FUSE] = fuse_s;
    st_set[`F_VER] = mism_s;
    st_set[`F_CHK] = check_err;
  end

  // Cleared by reset inside the bank, and all but the dip flag by an error reset request
  sticky_bits #(.W(`NSTICKY)) u_sticky (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .set(st_set),
    .clr(erst ? `CLR_ON_ERST : {`NSTICKY{1'b0}}),
    .q(sticky)
  );
  assign battery_alarm_indicator = sticky[`F_BATL];

  // ****************************************
  // Supply dip timing
  // ****************************************
  // A longer outage takes the supply down, so only short ones are counted
  reg [DIP_W-1:0] out_cnt_r;
  reg pok_d_r;
  wire [DIP_W-1:0] dip_lim = dc_s ? DC_LIM : AC_LIM;

  always @* begin
    dip_evt = pok_s & ~pok_d_r & (out_cnt_r <= dip_lim);
  end

  // ****************************************
  // Live flags, CPU state, LEDs, clock
  // ****************************************
  reg bat_live_r;
  reg ann_det_r;
  reg [3:0] state_r;
  reg pause_d_r;
  reg [1:0] warm_r;
  reg cset_arm_r;
  reg clk_err_r;
  reg chg_ok_r;
  wire [63:0] clk_words = {clkw_r[3], clkw_r[2], clkw_r[1], clkw_r[0]};

  function bcd_in;
    input [7:0] v;
    input [7:0] lo;
    input [7:0] hi;
    begin
      bcd_in = (v[7:4] <= `BCD_DIGIT_MAX) && (v[3:0] <= `BCD_DIGIT_MAX) &&
        (v >= lo) && (v <= hi);
    end
  endfunction

  // Word 0 month:year, 1 hour:day, 2 second:minute, 3 day of week
  wire clk_valid = bcd_in(clk_words[7:0], `BCD_ZERO, `BCD_YEAR_MAX) &&
    bcd_in(clk_words[15:8], `BCD_MON_MIN, `BCD_MON_MAX) &&
    bcd_in(clk_words[23:16], `BCD_DAY_MIN, `BCD_DAY_MAX) &&
    bcd_in(clk_words[31:24], `BCD_ZERO, `BCD_HOUR_MAX) &&
    bcd_in(clk_words[39:32], `BCD_ZERO, `BCD_MS_MAX) &&
    bcd_in(clk_words[47:40], `BCD_ZERO, `BCD_MS_MAX) &&
    bcd_in(clk_words[55:48], `BCD_ZERO, `BCD_DOW_MAX);

  always @(posedge aclk) begin
    if (!aresetn) begin
      // Saturated, so the synchroniser filling after reset is no short outage
      out_cnt_r <= DIP_MAX;
      pok_d_r <= 1'b1;
      warm_r <= 2'b00;
      bat_live_r <= 1'b0;
      ann_det_r <= 1'b0;
      state_r <= S_STOP;
      pause_d_r <= 1'b0;
      led_enable <= {LEDS{1'b1}};
      cset_arm_r <= 1'b0;
      clk_err_r <= 1'b0;
      rtc_wr <= 1'b0;
      rtc_wr_data <= 64'h0;
      step_timer_run <= {WDOGS{1'b0}};
      link_rd_go <= {LINKS{1'b0}};
      link_wr_go <= {LINKS{1'b0}};
      chg_ok_r <= 1'b0;
      module_change_grant <= 1'b0;
      change_io <= `WORD_RST;
    end else if (ce) begin
      pok_d_r <= pok_s;
      if (pok_s)
        out_cnt_r <= {DIP_W{1'b0}};
      else if (out_cnt_r != DIP_MAX)
        out_cnt_r <= out_cnt_r + 1'b1;
      bat_live_r <= bat_s;
      if (instr_exec)
        ann_det_r <= annunciator_any;
      pause_d_r <= pause_s;
      warm_r <= {warm_r[0], 1'b1};
      case (state_r)
        S_RUN: begin
          if (stop_s)
            state_r <= S_STOP;
          else if (step_s)
            state_r <= S_STEP;
          else if (pause_s & ~pause_d_r & ctrl_r[`CTL_PEN])
            state_r <= S_PAUSE;
        end
        S_STOP: begin
          // Switch levels are stale until both sync stages refill after reset
          if (!stop_s && warm_r[1])
            state_r <= step_s ? S_STEP : S_RUN;
        end
        S_PAUSE: begin
          if (stop_s)
            state_r <= S_STOP;
          else if (!pause_s)
            state_r <= S_RUN;
        end
        S_STEP: begin
          if (stop_s)
            state_r <= S_STOP;
          else if (!step_s)
            state_r <= S_RUN;
        end
        default: state_r <= S_STOP;
      endcase
      if (ctl_rise[`CTL_LEDOFF])
        led_enable <= led_enable & ~ledsel_r;
      // Write waits for the end of the scan after the request edge
      rtc_wr <= 1'b0;
      if (cset_arm_r && end_of_scan) begin
        cset_arm_r <= 1'b0;
        clk_err_r <= ~clk_valid;
        rtc_wr <= clk_valid;
        rtc_wr_data <= clk_words;
      end else if (ctl_rise[`CTL_CSET]) begin
        cset_arm_r <= 1'b1;
      end
      step_timer_run <= wdog_r & {WDOGS{sfc_present}};
      link_rd_go <= link_rd_req & ~link_r[LINKS-1:0];
      link_wr_go <= link_wr_req & ~link_r[2*LINKS-1:LINKS];
      // One grant per rising edge of the change bit
      module_change_grant <= ctl_rise[`CTL_CHG];
      if (ctl_rise[`CTL_CHG])
        change_io <= headio_r;
      if (!ctrl_r[`CTL_CHG] || module_change_done)
        chg_ok_r <= 1'b0;
      else if (module_change_grant)
        chg_ok_r <= 1'b1;
    end
  end

  assign stopped_contact = state_r[1];
  assign paused_contact = state_r[2];
  assign single_step_contact = state_r[3];

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  reg aw_hold_r;
  reg w_hold_r;
  reg [AW-1:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}},
    {8{wstrb_r[0]}}};
  wire [AW-1:0] clk_base = awaddr_r & ~`CLK_IDX_MASK;
  wire wr_go = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_r & ~s_axi_bvalid;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] m;
    begin
      merge = (old & ~m) | (nw & m);
    end
  endfunction

  wire [31:0] ctrl_nxt = merge({26'h0, ctrl_r}, wdata_r, wmask);
  wire [31:0] ledsel_nxt = merge({16'h0, ledsel_r}, wdata_r, wmask);
  wire [31:0] wdog_nxt = merge({22'h0, wdog_r}, wdata_r, wmask);
  wire [31:0] link_nxt = merge({24'h0, link_r}, wdata_r, wmask);
  wire [31:0] headio_nxt = merge({16'h0, headio_r}, wdata_r, wmask);
  wire [31:0] clkw_nxt = merge({16'h0, clkw_r[awaddr_r[3:2]]}, wdata_r, wmask);
  reg wr_hit;

  always @* begin
    wr_hit = 1'b1;
    case (awaddr_r)
      `OFF_CTRL, `OFF_LEDSEL, `OFF_WDOG, `OFF_LINK, `OFF_HEADIO: wr_hit = 1'b1;
      default: wr_hit = (clk_base == `OFF_CLK0);
    endcase
  end

  integer i;
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= {AW{1'b0}};
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      ctrl_r <= `CTL_RST;
      ctrl_d_r <= `CTL_RST;
      ledsel_r <= {LEDS{1'b0}};
      wdog_r <= {WDOGS{1'b0}};
      link_r <= {2*LINKS{1'b0}};
      headio_r <= `WORD_RST;
      for (i = 0; i < 4; i = i + 1)
        clkw_r[i] <= `WORD_RST;
    end else if (ce) begin
      ctrl_d_r <= ctrl_r;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        case (awaddr_r)
          `OFF_CTRL: ctrl_r <= ctrl_nxt[`CTL_W-1:0];
          `OFF_LEDSEL: ledsel_r <= ledsel_nxt[LEDS-1:0];
          `OFF_WDOG: wdog_r <= wdog_nxt[WDOGS-1:0];
          `OFF_LINK: link_r <= link_nxt[2*LINKS-1:0];
          `OFF_HEADIO: headio_r <= headio_nxt[15:0];
          default: begin
            if (clk_base == `OFF_CLK0)
              clkw_r[awaddr_r[3:2]] <= clkw_nxt[15:0];
          end
        endcase
      end
      // Live clock copy wins over a bus write to the clock words
      if (ctrl_r[`CTL_CRD]) begin
        for (i = 0; i < 4; i = i + 1)
          clkw_r[i] <= rtc_now[16*i +: 16];
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign s_axi_arready = ~s_axi_rvalid;
  wire [AW-1:0] rd_base = s_axi_araddr & ~`CLK_IDX_MASK;
  reg [31:0] rd_mux;
  reg rd_hit;

  always @* begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `OFF_STATUS: rd_mux = {15'h0, chg_ok_r, clk_err_r, state_r[3], state_r[2],
        state_r[1], ann_det_r, bat_live_r, sticky};
      `OFF_CTRL: rd_mux = {26'h0, ctrl_r};
      `OFF_LEDSEL: rd_mux = {16'h0, ledsel_r};
      `OFF_LEDST: rd_mux = {16'h0, led_enable};
      `OFF_WDOG: rd_mux = {22'h0, wdog_r};
      `OFF_LINK: rd_mux = {24'h0, link_r};
      `OFF_HEADIO: rd_mux = {16'h0, headio_r};
      default: begin
        rd_hit = (rd_base == `OFF_CLK0);
        if (rd_hit)
          rd_mux = {16'h0, clkw_r[s_axi_araddr[3:2]]};
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

//--- plc_system_flag_bank_properties.sv
// Port-level assertions for the system flag bank.
// Assumes ce stays high and the bank's default link, timer and LED widths.
`timescale 1ns/1ns
module flag_bank_checker (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire battery_low,
  input wire battery_alarm_indicator,
  input wire stop_switch,
  input wire stopped_contact,
  input wire paused_contact,
  input wire single_step_contact,
  input wire sfc_present,
  input wire [9:0] step_timer_run,
  input wire [3:0] link_rd_req,
  input wire [3:0] link_wr_req,
  input wire [3:0] link_rd_go,
  input wire [3:0] link_wr_go,
  input wire end_of_scan,
  input wire rtc_wr,
  input wire module_change_grant,
  input wire [15:0] led_enable
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response missing");
  // Pin path is two sync flops plus the flag
  a_alarm_latch: assert property (
    battery_low [*4] |=> battery_alarm_indicator)
    else $error("battery alarm not lit");
  a_stop_contact: assert property (
    stop_switch [*4] |=> stopped_contact)
    else $error("stop contact missing");
  a_contacts_excl: assert property (
    $onehot0({stopped_contact, paused_contact, single_step_contact}))
    else $error("two state contacts on");
  a_timer_gate: assert property (
    !sfc_present |=> step_timer_run == 10'h000)
    else $error("step timer runs without chart");
  a_link_gate: assert property (
    ((link_rd_go & ~$past(link_rd_req)) | (link_wr_go & ~$past(link_wr_req))) == 4'h0)
    else $error("link refresh without request");
  a_rtc_pulse: assert property (
    rtc_wr |-> $past(end_of_scan) ##1 !rtc_wr)
    else $error("clock write not a pulse after scan end");
  a_grant_pulse: assert property (
    module_change_grant |=> !module_change_grant)
    else $error("change grant longer than one cycle");
  a_led_no_relight: assert property (
    (led_enable & ~$past(led_enable)) == 16'h0000)
    else $error("LED relit without reset");
endmodule

bind plc_system_flag_bank flag_bank_checker chk (.*);

//--- plc_system_flag_bank_bench.sv
// Self-checking bench for the system flag bank.
// Assumes default widths; dip windows are cut to 40 and 8 cycles.
`timescale 1ns/1ns
`include "flag_bank_map.vh"
module plc_system_flag_bank_bench;
  logic aclk = 0, aresetn = 0, ce = 1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf, link_rd_req = 4'h0, link_wr_req = 4'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, fuse_blown = 0, battery_low = 0, power_ok = 1, supply_is_dc = 0;
  logic stop_switch = 1, pause_switch = 0, step_switch = 0, module_mismatch = 0;
  logic annunciator_any = 0, common_info_avail = 0, indiv_info_avail = 0, sfc_present = 0;
  logic [63:0] rtc_now = 64'h0, w;
  logic [5:0] pls = 6'h00;
  wire check_err = pls[0], op_err = pls[1], self_diag_err = pls[2], instr_exec = pls[3],
    end_of_scan = pls[4], module_change_done = pls[5];
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] led_enable, change_io;
  wire battery_alarm_indicator, stopped_contact, paused_contact, single_step_contact;
  wire rtc_wr, module_change_grant;
  wire [63:0] rtc_wr_data;
  wire [9:0] step_timer_run;
  wire [3:0] link_rd_go, link_wr_go;
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  logic [63:0] cq[$];
  logic [15:0] gq[$];
  logic [65:0] t;
  logic [31:0] r;
  int n_errors = 0, comparisons = 0, cnt = 0;

  plc_system_flag_bank #(.DIP_AC_CYC(40), .DIP_DC_CYC(8)) dut (.*);

  always #5 aclk = ~aclk;

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string nm, input logic [63:0] s, input logic [63:0] e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  task end_sim;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task pulse(input int b);
    pls[b] <= 1'b1;
    cyc(1);
    pls[b] <= 1'b0;
  endtask

  task wr(input [7:0] a, input [31:0] d, input [1:0] e);
    bq.push_back(e);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    fork
      begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 0; end
      begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 0; end
    join
    s_axi_bready <= 1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask

  task rd(input [7:0] a, input [31:0] e, input [31:0] m, input [1:0] p);
    rq.push_back({p, m, e & m});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
  endtask

  task st(input [31:0] e, input [31:0] m);
    rd(`OFF_STATUS, e, m, `RESP_OKAY);
  endtask

  task erst;
    wr(`OFF_CTRL, 32'h1, `RESP_OKAY);
    wr(`OFF_CTRL, 32'h0, `RESP_OKAY);
  endtask

  // ****************************************
  // Result watcher and timeout
  // ****************************************
  always @(posedge aclk) begin
    cnt <= cnt + 1;
    if (s_axi_rvalid && s_axi_rready) begin
      t = rq.pop_front();
      check("rdata", s_axi_rdata & t[63:32], t[31:0]);
      check("rresp", s_axi_rresp, t[65:64]);
    end
    if (s_axi_bvalid && s_axi_bready) check("bresp", s_axi_bresp, bq.pop_front());
    if (rtc_wr) check("rtc_data", rtc_wr_data, cq.size() ? cq.pop_front() : ~rtc_wr_data);
    if (module_change_grant) check("change_io", change_io, gq.size() ? gq.pop_front() : ~change_io);
    if (cnt == 5000) begin
      n_errors++;
      end_sim;
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    void'($urandom(32'hcab9c582));
    cyc(4);
    aresetn <= 1;
    cyc(1);
    st(32'h1000, 32'h1ffff);
    rd(`OFF_LEDST, 32'hffff, '1, `RESP_OKAY);
    rd(8'h40, 32'h0, '1, `RESP_SLVERR);
    wr(`OFF_STATUS, '1, `RESP_SLVERR);
    wr(8'h44, '1, `RESP_SLVERR);
    indiv_info_avail <= 1;
    pulse(0);
    indiv_info_avail <= 0;
    st(32'h0209, 32'h0b4f);
    common_info_avail <= 1;
    pulse(1);
    pulse(2);
    common_info_avail <= 0;
    st(32'h024f, 32'h0b4f);
    erst;
    indiv_info_avail <= 1;
    cyc(2);
    st(32'h0, 32'h0b4f);
    indiv_info_avail <= 0;
    annunciator_any <= 1;
    cyc(2);
    st(32'h0, 32'h0802);
    pulse(3);
    st(32'h0801, 32'h0803);
    annunciator_any <= 0;
    pulse(3);
    st(32'h0001, 32'h0803);
    fuse_blown <= 1;
    module_mismatch <= 1;
    battery_low <= 1;
    cyc(5);
    st(32'h0590, 32'h05b0);
    fuse_blown <= 0;
    module_mismatch <= 0;
    battery_low <= 0;
    cyc(5);
    st(32'h0190, 32'h05b0);
    power_ok <= 0;
    cyc(20);
    power_ok <= 1;
    cyc(6);
    st(32'h0020, 32'h0020);
    erst;
    st(32'h0020, 32'h05f0);
    aresetn <= 0;
    cyc(4);
    aresetn <= 1;
    cyc(1);
    st(32'h1000, 32'h1ffff);
    supply_is_dc <= 1;
    power_ok <= 0;
    cyc(5);
    power_ok <= 1;
    cyc(6);
    st(32'h0020, 32'h0020);
    w = {16'h0006, 8'h59, 4'($urandom % 6), 4'($urandom % 10), 16'h2331, 8'h12,
      4'($urandom % 10), 4'($urandom % 10)};
    for (int i = 0; i < 4; i++) wr(8'(32 + 4 * i), {16'h0, w[16 * i +: 16]}, `RESP_OKAY);
    cq.push_back(w);
    wr(`OFF_CTRL, 32'h8, `RESP_OKAY);
    cyc(2);
    pulse(4);
    cyc(3);
    st(32'h0, 32'h8000);
    wr(8'h2c, 32'h7, `RESP_OKAY);
    wr(`OFF_CTRL, 32'h0, `RESP_OKAY);
    wr(`OFF_CTRL, 32'h8, `RESP_OKAY);
    cyc(2);
    pulse(4);
    cyc(3);
    st(32'h8000, 32'h8000);
    rtc_now <= {$urandom, $urandom};
    wr(`OFF_CTRL, 32'h10, `RESP_OKAY);
    cyc(2);
    for (int i = 0; i < 4; i++) rd(8'(32 + 4 * i), {16'h0, rtc_now[16 * i +: 16]}, '1, 0);
    r = 32'hffff;
    for (int i = 0; i < 2; i++) begin
      w[15:0] = 16'($urandom);
      r[15:0] = r[15:0] & ~w[15:0];
      wr(`OFF_LEDSEL, {16'h0, w[15:0]}, `RESP_OKAY);
      wr(`OFF_CTRL, 32'h2, `RESP_OKAY);
      wr(`OFF_CTRL, 32'h0, `RESP_OKAY);
      rd(`OFF_LEDST, r, '1, `RESP_OKAY);
    end
    stop_switch <= 0;
    pause_switch <= 1;
    cyc(4);
    st(32'h0, 32'h7000);
    pause_switch <= 0;
    wr(`OFF_CTRL, 32'h4, `RESP_OKAY);
    cyc(4);
    pause_switch <= 1;
    cyc(4);
    st(32'h2000, 32'h7000);
    pause_switch <= 0;
    cyc(4);
    step_switch <= 1;
    cyc(4);
    st(32'h4000, 32'h7000);
    step_switch <= 0;
    stop_switch <= 1;
    cyc(4);
    st(32'h1000, 32'h7000);
    r = $urandom;
    wr(`OFF_WDOG, r, `RESP_OKAY);
    cyc(2);
    check("timer", step_timer_run, 64'h0);
    sfc_present <= 1;
    cyc(2);
    check("timer", step_timer_run, r[9:0]);
    r = $urandom;
    wr(`OFF_LINK, r, `RESP_OKAY);
    link_rd_req <= 4'hf;
    link_wr_req <= 4'hf;
    cyc(2);
    check("rd_go", link_rd_go, 4'(~r[3:0]));
    check("wr_go", link_wr_go, 4'(~r[7:4]));
    s_axi_wstrb <= 4'h1;
    r = $urandom;
    wr(`OFF_HEADIO, r, `RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    gq.push_back({8'h00, r[7:0]});
    wr(`OFF_CTRL, 32'h20, `RESP_OKAY);
    cyc(2);
    st(32'h10000, 32'h10000);
    pulse(5);
    cyc(2);
    st(32'h0, 32'h10000);
    cyc(2);
    check("pending", rq.size() + bq.size() + cq.size() + gq.size(), 64'h0);
    end_sim;
  end
endmodule
